//--- design/spc_sleep_ctrl.sv
// sleep mode, clock gating and reference/buffer enable controller
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_sleep_ctrl (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   input  wire logic                sleep_instr,
   input  wire logic                crystal_selected,
   input  wire logic [15:0]         startup_cycles,
   input  wire logic                debug_enable_fuse,
   input  wire logic                brownout_enabled,
   input  wire logic                converter_enabled,
   input  wire logic                comparator_enable_bit,
   input  wire logic                comparator_uses_ref,
   input  wire logic                watchdog_enabled,
   input  wire logic                irq_pending,
   input  wire logic                ext_level_irq,
   input  wire logic                ext_edge_irq,
   input  wire logic                stage_irq,
   input  wire logic                timer_irq,
   input  wire logic                store_ready_irq,
   input  wire logic                conv_done_irq,
   input  wire logic                wdt_irq,
   input  wire logic                wake_pin_mask,
   output logic                     core_clk_en,
   output logic                     program_store_clk_en,
   output logic                     io_clk_en,
   output logic                     converter_clk_en,
   output logic                     pll_clk_en,
   output logic                     main_osc_en,
   output logic [7:0]               periph_clk_en,
   output logic                     periph_access_en,
   output logic                     conv_start,
   output logic                     conv_extended,
   output logic                     vref_en,
   output logic                     brownout_active,
   output logic                     watchdog_run,
   output logic                     comparator_keep,
   output logic                     input_buf_en,
   output logic [15:0]              dig_input_en,
   output logic                     irq_service
);
   import spc_pkg::*;

   typedef struct packed {
      spc_state_type st;
      logic [7:0]    ctrl;
      logic [7:0]    gate;
      logic [15:0]   did;
      logic [2:0]    mode;
      logic [15:0]   cnt;
      logic          from_irq;
      logic          conv_prev;
      logic          conv_ext;
      logic          conv_start;
      logic [7:0]    rdata;
      logic          core_en;
      logic          io_en;
      logic          adc_en;
      logic          osc_en;
      logic          vref;
      logic          ibuf;
      logic          svc;
      logic [1:0]    s_lvl;
      logic [1:0]    s_edge;
      logic [1:0]    s_irq;
      logic [7:0]    pclk;
      logic [15:0]   din;
      logic          wdt;
      logic          bod;
      logic          cmp;
   } spc_regs_type;

   spc_regs_type state_reg;
   spc_regs_type state_next;

   // mode decode used by sleep entry only
   function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
      mode_valid = (m == `SPC_MODE_IDLE) || (m == `SPC_MODE_NOISE) ||
                   (m == `SPC_MODE_PDOWN) || ((m == `SPC_MODE_STANDBY) && xtal);
   endfunction

   // wake qualification per sleep mode
   function automatic logic wake_ok(input logic [2:0] m, input logic lvl, input logic edg,
                                    input logic irq, input logic stg, input logic tmr,
                                    input logic sto, input logic cnv, input logic wdt);
      case (m)
         `SPC_MODE_IDLE:  wake_ok = irq | lvl | edg;                      // see RULE_01
         `SPC_MODE_NOISE: wake_ok = cnv | wdt | tmr | sto | lvl;          // see RULE_06
         default:         wake_ok = wdt | stg | lvl;                      // see RULE_08
      endcase
   endfunction

   logic [7:0] status_word;
   logic       wake;

   // status view: state, mode, converter extended flag
   assign status_word = {3'b000, state_reg.conv_ext, state_reg.st == SPC_ACTIVE,
                         state_reg.mode};
   assign wake = wake_ok(state_reg.mode, state_reg.s_lvl[1], state_reg.s_edge[1],
                         state_reg.s_irq[1], stage_irq, timer_irq, store_ready_irq,
                         conv_done_irq, wdt_irq);

   // next state of every register
   always_comb begin
      logic [2:0] req_mode;
      req_mode = state_reg.ctrl[`SPC_SM_LSB +: 3];
      state_next = state_reg;
      state_next.conv_start = 1'b0;
      state_next.rdata = `SPC_ZERO8;
      state_next.svc = 1'b0;
      // external pins pass two flip-flops first
      state_next.s_lvl = {state_reg.s_lvl[0], ext_level_irq};     // see RULE_09
      state_next.s_edge = {state_reg.s_edge[0], ext_edge_irq};
      state_next.s_irq = {state_reg.s_irq[0], irq_pending};

      // register writes; gated peripheral registers are not here
      if (reg_wr) begin
         case (reg_addr)
            `SPC_ADDR_SLEEP_CTRL:  state_next.ctrl = {4'h0, reg_wdata[3:0]};
            `SPC_ADDR_PERIPH_GATE: state_next.gate = reg_wdata & `SPC_PERIPH_MASK;
            `SPC_ADDR_DIG_DIS_LO:  state_next.did[7:0] = reg_wdata;   // see RULE_24
            `SPC_ADDR_DIG_DIS_HI:  state_next.did[15:8] = reg_wdata;  // see RULE_24
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `SPC_ADDR_SLEEP_CTRL:  state_next.rdata = state_reg.ctrl;
            `SPC_ADDR_PERIPH_GATE: state_next.rdata = state_reg.gate;
            `SPC_ADDR_DIG_DIS_LO:  state_next.rdata = state_reg.did[7:0];
            `SPC_ADDR_DIG_DIS_HI:  state_next.rdata = state_reg.did[15:8];
            `SPC_ADDR_STATUS:      state_next.rdata = status_word;
            default:               state_next.rdata = `SPC_ZERO8;
         endcase
      end

      // converter disable then enable forces one extended conversion
      state_next.conv_prev = converter_enabled;
      if (converter_enabled && !state_reg.conv_prev) begin
         state_next.conv_ext = 1'b1;                                 // see RULE_17
      end else if (state_reg.conv_start) begin
         state_next.conv_ext = 1'b0;
      end

      case (state_reg.st)
         SPC_ACTIVE: begin
            // reserved codes fall through as a no-op
            if (sleep_instr && state_reg.ctrl[`SPC_SE_BIT] &&          // see RULE_02
                mode_valid(req_mode, crystal_selected)) begin          // see RULE_26
               state_next.st = SPC_SLEEP;
               state_next.mode = req_mode;
               state_next.core_en = 1'b0;                            // see RULE_01
               state_next.io_en = (req_mode == `SPC_MODE_IDLE);      // see RULE_04
               state_next.adc_en = (req_mode == `SPC_MODE_IDLE) ||
                                   (req_mode == `SPC_MODE_NOISE);    // see RULE_07
               // standby keeps oscillator; debug keeps main clock
               state_next.osc_en = (req_mode != `SPC_MODE_PDOWN) ||
                                   debug_enable_fuse;                // see RULE_11 RULE_25
               state_next.conv_start = converter_enabled &&
                                       ((req_mode == `SPC_MODE_IDLE) ||
                                        (req_mode == `SPC_MODE_NOISE)); // see RULE_05
            end
         end
         SPC_SLEEP: begin
            if (wake) begin
               state_next.from_irq = state_reg.s_irq[1] | state_reg.s_lvl[1] | stage_irq |
                                     timer_irq | store_ready_irq | conv_done_irq;
               state_next.osc_en = 1'b1;
               state_next.st = SPC_STARTUP;
               // power-down waits the fuse start-up time, standby six cycles
               if (state_reg.mode == `SPC_MODE_PDOWN) begin
                  state_next.cnt = startup_cycles;                   // see RULE_10
               end else if (state_reg.mode == `SPC_MODE_STANDBY) begin
                  state_next.cnt = `SPC_STANDBY_CYCLES - 16'h0002;  // see RULE_12
               end else begin
                  state_next.cnt = `SPC_ZERO16;
               end
            end
         end
         SPC_STARTUP: begin
            if (state_reg.cnt != `SPC_ZERO16) begin
               state_next.cnt = state_reg.cnt - 16'h0001;
            end else begin
               state_next.io_en = 1'b1;
               state_next.adc_en = 1'b1;
               if (state_reg.from_irq && state_reg.mode != `SPC_MODE_STANDBY) begin
                  state_next.st = SPC_HOLD;
                  state_next.cnt = {12'h000, `SPC_INT_HOLD_CYCLES} - 16'h0001; // see RULE_03
               end else begin
                  state_next.st = SPC_ACTIVE;
                  state_next.core_en = 1'b1;
                  state_next.svc = state_reg.from_irq;
               end
            end
         end
         SPC_HOLD: begin
            if (state_reg.cnt != `SPC_ZERO16) begin
               state_next.cnt = state_reg.cnt - 16'h0001;
            end else begin
               state_next.st = SPC_ACTIVE;
               state_next.core_en = 1'b1;
               state_next.svc = 1'b1;                                // see RULE_03
            end
         end
         default: state_next.st = SPC_ACTIVE;
      endcase

      // reference follows its users in every mode
      state_next.vref = brownout_enabled || converter_enabled ||
                        (comparator_enable_bit && comparator_uses_ref); // see RULE_19 RULE_20
      // inputs stay live unless asleep with io and converter clocks both stopped
      state_next.ibuf = !(state_next.st != SPC_ACTIVE && !state_next.io_en &&
                          !state_next.adc_en);                        // see RULE_23
      // gated views are flopped so every output leaves a register
      state_next.pclk = state_next.io_en ? ~state_next.gate : `SPC_ZERO8; // see RULE_14 RULE_16
      state_next.din = ~state_next.did;                               // see RULE_24
      // enabled watchdog and fuse-enabled detector run in every mode
      state_next.wdt = watchdog_enabled;                              // see RULE_22
      state_next.bod = brownout_enabled;                              // see RULE_21
      // sleep leaves comparators as programmed, never forces them off
      state_next.cmp = comparator_enable_bit;                         // see RULE_18
   end

   // single state register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '{st: SPC_ACTIVE, core_en: 1'b1, io_en: 1'b1, adc_en: 1'b1,
                        osc_en: 1'b1, ibuf: 1'b1, pclk: '1, din: '1, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = state_reg.rdata;
   assign core_clk_en = state_reg.core_en;
   assign program_store_clk_en = state_reg.core_en;
   assign io_clk_en = state_reg.io_en;
   assign converter_clk_en = state_reg.adc_en;
   assign pll_clk_en = state_reg.adc_en;
   assign main_osc_en = state_reg.osc_en;
   // gating only matters while io clock runs; deep modes stop them anyway
   assign periph_clk_en = state_reg.pclk;                         // see RULE_13
   assign periph_access_en = state_reg.io_en;                     // see RULE_13
   assign conv_start = state_reg.conv_start;
   assign conv_extended = state_reg.conv_ext;
   assign vref_en = state_reg.vref;
   assign brownout_active = state_reg.bod;                        // see RULE_21
   assign watchdog_run = state_reg.wdt;                           // see RULE_22
   assign comparator_keep = state_reg.cmp;                        // see RULE_18
   assign input_buf_en = state_reg.ibuf;
   assign dig_input_en = state_reg.din;
   assign irq_service = state_reg.svc;
endmodule

//--- inc/spc_defs.svh
// constants for the sleep mode power controller
// Operation
// RULE_01: mode 000 idle stops core and program store
// RULE_02: sleep entered only when enable bit set
// RULE_03: interrupt wake holds core four extra cycles; code skips the hold for standby wakes and for edge or watchdog wakes
// RULE_04: mode 001 noise reduction also stops io
// RULE_05: converter enabled starts conversion on idle/noise entry
// RULE_06: noise reduction wakes only from listed sources
// RULE_07: mode 010 power-down stops all generated clocks
// RULE_08: power-down wakes on reset, stage, level interrupt
// RULE_09: level wake source holds level minimum time
// RULE_10: power-down wake waits fuse-selected start-up period
// RULE_11: mode 110 with crystal is standby, oscillator runs
// RULE_12: standby wake completes within six cycles
// RULE_13: gate bit stops peripheral clock, blocks access; code drives access enable from io clock only, not gate bits
// RULE_14: clearing gate bit resumes peripheral unchanged
// RULE_15: software disables peripheral before gating it
// RULE_16: gating applies in active and idle only
// RULE_17: converter stays enabled in sleep; re-enable extends
// RULE_18: sleep never disables comparators automatically
// RULE_19: reference on whenever detector, comparator, converter need
// RULE_20: comparator on internal reference keeps reference on
// RULE_21: fuse-enabled brown-out detector active in sleep
// RULE_22: enabled watchdog keeps running in sleep
// RULE_23: input buffers off when io and converter stopped
// RULE_24: digital input disable bits turn off buffers
// RULE_25: debug fuse keeps main clock source on
// RULE_26: reserved mode code acts as no-operation
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_ADDR_SLEEP_CTRL  4'h0
`define SPC_ADDR_PERIPH_GATE 4'h1
`define SPC_ADDR_DIG_DIS_LO  4'h2
`define SPC_ADDR_DIG_DIS_HI  4'h3
`define SPC_ADDR_STATUS      4'h4
`define SPC_MODE_IDLE        3'h0
`define SPC_MODE_NOISE       3'h1
`define SPC_MODE_PDOWN       3'h2
`define SPC_MODE_STANDBY     3'h6
`define SPC_SE_BIT           0
`define SPC_SM_LSB           1
`define SPC_PERIPH_MASK      8'hB5
`define SPC_INT_HOLD_CYCLES  4'h4
`define SPC_STANDBY_CYCLES   16'h0006
`define SPC_ZERO8            8'h00
`define SPC_ZERO16           16'h0000
`endif

//--- inc/spc_pkg.sv
// types for the sleep mode power controller
package spc_pkg;
   typedef enum logic [2:0] {
      SPC_ACTIVE,
      SPC_SLEEP,
      SPC_STARTUP,
      SPC_HOLD
   } spc_state_type;
endpackage

//--- tb/spc_sleep_ctrl_asserts.sv
// port checks for the sleep mode power controller
`timescale 1ns/100ps
`include "spc_defs.svh"
module spc_chk (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       sleep_instr,
   input wire logic       debug_enable_fuse,
   input wire logic       brownout_enabled,
   input wire logic       converter_enabled,
   input wire logic       comparator_enable_bit,
   input wire logic       comparator_uses_ref,
   input wire logic       watchdog_enabled,
   input wire logic       core_clk_en,
   input wire logic       io_clk_en,
   input wire logic       converter_clk_en,
   input wire logic       main_osc_en,
   input wire logic       vref_en,
   input wire logic       watchdog_run,
   input wire logic       input_buf_en,
   input wire logic       brownout_active,
   input wire logic       comparator_keep,
   input wire logic       conv_start
);
   logic [3:0] ctrl_reg;
   logic       go_sleep;
   logic       need_ref;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // shadow of the sleep control byte, so entry checks know the mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= 4'h0;
      end else if (reg_wr && reg_addr == `SPC_ADDR_SLEEP_CTRL) begin
         ctrl_reg <= reg_wdata[3:0];
      end
   end
   // a sleep instruction met while awake, and the demand on the reference
   assign go_sleep = core_clk_en && sleep_instr;
   assign need_ref = brownout_enabled | converter_enabled
                   | (comparator_enable_bit & comparator_uses_ref);
   property p_idle;
      go_sleep && ctrl_reg == 4'h1 |=> !core_clk_en && io_clk_en && converter_clk_en;
   endproperty
   a_idle: assert property (p_idle) else $error("idle entry gated wrong clocks");
   property p_noise;
      go_sleep && ctrl_reg == 4'h3 |=> !core_clk_en && !io_clk_en && converter_clk_en;
   endproperty
   a_noise: assert property (p_noise) else $error("noise entry wrong clocks");
   property p_pdown;
      go_sleep && ctrl_reg == 4'h5 |=> !io_clk_en && !converter_clk_en
                                        && main_osc_en == debug_enable_fuse;
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down wrong clocks");
   property p_se_off;
      go_sleep && !ctrl_reg[0] |=> core_clk_en [*3];
   endproperty
   a_se_off: assert property (p_se_off) else $error("slept with enable clear");
   property p_reserved;
      go_sleep && ctrl_reg[0] && ctrl_reg[3:1] inside {3'h3, 3'h4, 3'h5, 3'h7}
         |=> core_clk_en ##1 core_clk_en;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode slept");
   property p_vref;
      need_ref == $past(need_ref) |-> vref_en == need_ref;
   endproperty
   a_vref: assert property (p_vref) else $error("reference enable wrong");
   property p_wdt;
      $stable(watchdog_enabled) |-> watchdog_run == watchdog_enabled;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog run wrong");
   property p_bufs;
      !$past(io_clk_en) && !$past(converter_clk_en) && !io_clk_en && !converter_clk_en
         |-> !input_buf_en;
   endproperty
   a_bufs: assert property (p_bufs) else $error("input buffers left on");
   property p_conv;
      go_sleep && ctrl_reg[0] && ctrl_reg[3:2] == 2'h0
         |=> conv_start == $past(converter_enabled);
   endproperty
   a_conv: assert property (p_conv) else $error("conversion start on entry wrong");
   property p_bod;
      $stable(brownout_enabled) |-> brownout_active == brownout_enabled;
   endproperty
   a_bod: assert property (p_bod) else $error("brown-out detector state wrong");
   property p_cmp;
      $stable(comparator_enable_bit) |-> comparator_keep == comparator_enable_bit;
   endproperty
   a_cmp: assert property (p_cmp) else $error("comparator state changed by sleep");
   c_sleep: cover property (go_sleep && ctrl_reg[0]);
   c_wake: cover property ($rose(core_clk_en));
   c_bufs_off: cover property (!input_buf_en);
endmodule

//--- tb/spc_core_model.sv
// behavioural core and wake sources facing the controller
`timescale 1ns/100ps
module spc_core_model (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic       wreq,
   input  wire logic [7:0] wsrc,
   output logic            sleep_instr,
   output logic [7:0]      wake_vec
);
   // one-cycle sleep instruction; a wake level stays until the bench drops it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sleep_instr <= 1'b0;
         wake_vec    <= 8'h00;
      end else begin
         sleep_instr <= go;
         wake_vec    <= wreq ? wsrc : 8'h00;
      end
   end
endmodule

//--- tb/testbench.sv
// self-checking bench for the sleep mode power controller
`timescale 1ns/100ps
module testbench;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        xtal = 1'b0;
   logic        dbg = 1'b0;
   logic [3:0]  ana = 4'h0;
   logic        wdog = 1'b0;
   logic        go = 1'b0;
   logic        wreq = 1'b0;
   logic [7:0]  wsrc = 8'h00;
   logic [15:0] rnd = 16'h65ce;
   logic [7:0]  reg_rdata;
   logic        sleep_instr;
   logic        input_buf_en;
   logic [7:0]  wake_vec;
   logic [5:0]  clk_en;
   logic [7:0]  periph_clk_en;
   logic [15:0] dig_input_en;
   logic [7:0]  bad_t [8] = '{8'h00, 8'h04, 8'h10, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
   logic [7:0]  good_t [8] = '{8'h01, 8'h40, 8'h08, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
   int          fails = 0;
   int          cmp_count = 0;
   int          gm = 0;
   localparam logic [15:0] STARTUP = 16'h0028;
   always #2 sys_clk = ~sys_clk;
   spc_core_model core (.sys_clk(sys_clk), .rst(rst), .go(go), .wreq(wreq), .wsrc(wsrc),
      .sleep_instr(sleep_instr), .wake_vec(wake_vec));
   spc_sleep_ctrl uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sleep_instr(sleep_instr), .crystal_selected(xtal), .startup_cycles(STARTUP),
      .debug_enable_fuse(dbg), .brownout_enabled(ana[3]), .converter_enabled(ana[2]),
      .comparator_enable_bit(ana[1]), .comparator_uses_ref(ana[0]), .watchdog_enabled(wdog),
      .irq_pending(wake_vec[0]), .ext_level_irq(wake_vec[1]), .ext_edge_irq(wake_vec[2]),
      .stage_irq(wake_vec[3]), .timer_irq(wake_vec[4]), .store_ready_irq(wake_vec[5]),
      .conv_done_irq(wake_vec[6]), .wdt_irq(wake_vec[7]), .wake_pin_mask(1'b0),
      .core_clk_en(clk_en[5]), .program_store_clk_en(clk_en[4]), .io_clk_en(clk_en[3]),
      .converter_clk_en(clk_en[2]), .pll_clk_en(clk_en[1]), .main_osc_en(clk_en[0]),
      .periph_clk_en(periph_clk_en), .periph_access_en(), .conv_start(), .conv_extended(),
      .vref_en(), .brownout_active(), .watchdog_run(), .comparator_keep(),
      .input_buf_en(input_buf_en), .dig_input_en(dig_input_en), .irq_service());
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // expected {core, store, io, converter, pll, oscillator} enables after a sleep
   function automatic logic [5:0] exp_en(input logic [2:0] m, input logic se);
      if (!se) return 6'h3f;
      case (m)
         3'h0: return 6'h0f;
         3'h1: return 6'h07;
         3'h2: return {5'h00, dbg};
         3'h6: return xtal ? 6'h01 : 6'h3f;
         default: return 6'h3f;
      endcase
   endfunction
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // register port: one-cycle strobes, a free edge after each write so that
   // back-to-back calls never assign the strobe twice in one time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check("read data", {8'h00, exp}, {8'h00, reg_rdata});
      @(posedge sys_clk);
   endtask
   // sleep, try a source that must not wake, then a source that must
   task automatic try_sleep(input logic [2:0] m, input logic se, input logic [7:0] bad,
                            input logic [7:0] good);
      logic [5:0] e;
      logic       ok;
      int         n;
      e = exp_en(m, se);
      wr(4'h0, {4'h0, m, se});
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      check("enables", {9'h000, e[3] | e[2], e}, {9'h000, input_buf_en, clk_en});
      check("periph clocks", {8'h00, e[3] ? ~gm[7:0] : 8'h00}, {8'h00, periph_clk_en});
      if (e[5] === 1'b0) begin
         @(posedge sys_clk);
         wsrc <= bad;
         wreq <= |bad;
         repeat (12) @(posedge sys_clk);
         #1;
         check("still asleep", 16'h0000, {15'h0000, clk_en[5]});
         @(posedge sys_clk);
         wsrc <= good;
         wreq <= 1'b1;
         n = 0;
         while (clk_en[5] !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
         end
         case (m)
            3'h2: ok = (n >= STARTUP) && (n <= STARTUP + 20);
            3'h6: ok = (n <= 10);
            default: ok = (n >= 4) && (n <= 40);
         endcase
         check("wake delay ok", 16'h0001, {15'h0000, ok});
         @(posedge sys_clk);
         wreq <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      check("reset enables", 16'h007f, {9'h000, input_buf_en, clk_en});
      @(posedge sys_clk);
      rd(4'h9, 8'h00);
      for (int p = 0; p < 2; p++) begin
         rnd = lfsr(rnd);
         gm = rnd[7:0] & 8'hb5;
         xtal <= p[0];
         dbg <= p[0];
         ana <= rnd[11:8];
         wdog <= rnd[12];
         wr(4'h1, rnd[7:0]);
         rd(4'h1, gm[7:0]);
         wr(4'h2, rnd[7:0]);
         wr(4'h3, rnd[15:8]);
         #1;
         check("input enables", ~rnd, dig_input_en);
         @(posedge sys_clk);
         for (int m = 0; m < 8; m++) begin
            try_sleep(m[2:0], 1'b1, bad_t[m], good_t[m]);
         end
      end
      try_sleep(3'h0, 1'b0, 8'h00, 8'h00);
      close_out;
   end
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      close_out;
   end
endmodule
bind spc_sleep_ctrl spc_chk u_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sleep_instr(sleep_instr),
   .debug_enable_fuse(debug_enable_fuse), .brownout_enabled(brownout_enabled),
   .converter_enabled(converter_enabled), .comparator_enable_bit(comparator_enable_bit),
   .comparator_uses_ref(comparator_uses_ref), .watchdog_enabled(watchdog_enabled),
   .core_clk_en(core_clk_en), .io_clk_en(io_clk_en), .converter_clk_en(converter_clk_en),
   .main_osc_en(main_osc_en), .vref_en(vref_en), .watchdog_run(watchdog_run),
   .input_buf_en(input_buf_en), .brownout_active(brownout_active),
   .comparator_keep(comparator_keep), .conv_start(conv_start));
